// >>> verif/smoc_base_model.sv
`timescale 1ns/100ps
module smoc_base_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls
  input wire logic attach,
  input wire logic slow,
  // Module side
  input wire logic power_en,
  input wire logic shutdown_cmd,
  output logic base_attached,
  output logic base_active
);
  // ==========================================================================
  // Base unit: runs while powered, winds down on a shutdown command
  logic [5:0] cnt_q;

  assign base_attached = attach;

  // Detached base line is pulled low; saving takes a short or long time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      base_active <= 1'b0;
    end else if (!attach) begin
      cnt_q <= 6'h00;
      base_active <= 1'b0;
    end else if (shutdown_cmd) begin
      cnt_q <= cnt_q + 6'h01;
      if (cnt_q == (slow ? 6'h28 : 6'h02)) base_active <= 1'b0;
    end else begin
      cnt_q <= 6'h00;
      base_active <= power_en;
    end
  end
endmodule // smoc_base_model

// >>> verif/smoc_ctrl_properties.sv
`timescale 1ns/100ps
module smoc_ctrl_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Watched inputs
  input wire logic mute,
  input wire logic ext_supply_ok,
  input wire logic base_attached,
  input wire logic base_active,
  input wire logic reset_button,
  // Watched outputs
  input wire logic power_en,
  input wire logic shutdown_cmd,
  input wire logic buzzer
);
  // ==========================================================================
  // Run lengths of steady inputs
  logic [3:0] mute_q, ext_q, att_q, idle_q, rbl_q;

  function automatic logic [3:0] run(input logic c, input logic [3:0] v);
    return c ? v + {3'h0, v != 4'hF} : 4'h0;
  endfunction

  // Saturate at 15 so a long steady level outlasts the debounce path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mute_q, ext_q, att_q, idle_q, rbl_q} <= '0;
    end else begin
      mute_q <= run(mute, mute_q);
      ext_q <= run(ext_supply_ok, ext_q);
      att_q <= run(base_attached, att_q);
      idle_q <= run(!base_active, idle_q);
      rbl_q <= run(!reset_button, rbl_q);
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_stands; pready |=> !pready; endproperty
  a_stands: assert property (p_stands) else $error("ready held too long");
  property p_reset_btn; reset_button [*8] ##1 reset_button [*8] |-> !power_en; endproperty
  a_reset_btn: assert property (p_reset_btn) else $error("on while reset held");
  property p_mute; mute_q == 4'hF |-> !buzzer; endproperty
  a_mute: assert property (p_mute) else $error("buzzer while muted");
  property p_silent; ext_q == 4'hF |-> !buzzer; endproperty
  a_silent: assert property (p_silent) else $error("buzzer on supply");
  property p_buzz_on; $rose(buzzer) |-> power_en; endproperty
  a_buzz_on: assert property (p_buzz_on) else $error("buzzer while off");
  property p_base_off; $fell(power_en) && att_q == 4'hF && rbl_q == 4'hF |-> idle_q > 4'h3; endproperty
  a_base_off: assert property (p_base_off) else $error("cut under active base");
  property p_shdn_on; $rose(shutdown_cmd) |-> power_en; endproperty
  a_shdn_on: assert property (p_shdn_on) else $error("shutdown while off");
  property p_hold; shutdown_cmd && base_active && att_q == 4'hF && rbl_q == 4'hF |=> power_en; endproperty
  a_hold: assert property (p_hold) else $error("off before base idle");
endmodule // smoc_ctrl_properties

bind smoc_ctrl smoc_ctrl_properties u_props (.*);

// >>> verif/test_supply_module_on_off_control.sv
`timescale 1ns/100ps
module test_supply_module_on_off_control;
  // ==========================================================================
  // Signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic remote_on, remote_off, always_on_bridge, mute, ext_supply_ok, net_above_3v, net_above_2v;
  logic base_attached, base_button, base_active, reset_button, power_en, shutdown_cmd, buzzer;
  logic attach, slow;
  logic [3:0] buf_sel;
  int checked, n_mismatch;

  smoc_ctrl #(.DB_CYC(4), .TICK_CYC(20)) DUT (.*);
  smoc_base_model u_base (.*);

  // Free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      end_of_test();
    end
    @(posedge pclk); // Idle edge: no strobe is assigned twice in one step
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask

  // Contact held past the debounce window, then settled: 0 remote on, 1 remote off, 2 base button
  task automatic press(input int k);
    for (int v = 1; v >= 0; v--) begin
      case (k)
        0: remote_on <= v[0];
        1: remote_off <= v[0];
        default: base_button <= v[0];
      endcase
      cyc(v == 1 ? 10 : 12);
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd("ctrl reset", smoc_pkg::OFS_CTRL, 32'h0);
    rd("mask reset", smoc_pkg::OFS_IRQ_MASK, 32'h0);
    rd("status pin sel", smoc_pkg::OFS_STATUS, 32'h0000_0F00);
    wr(smoc_pkg::OFS_CTRL, 32'h15);
    rd("ctrl rw", smoc_pkg::OFS_CTRL, 32'h15);
    rd("status ovr sel", smoc_pkg::OFS_STATUS, 32'h0000_0500);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask

  task automatic t_remote();
    press(0);
    chk("on by remote", power_en, 32'h1);
    chk("irq masked", irq, 32'h0);
    wr(smoc_pkg::OFS_IRQ_MASK, 32'h3);
    cyc(2);
    chk("irq raised", irq, 32'h1);
    wr(smoc_pkg::OFS_IRQ_STAT, 32'h1F);
    cyc(2);
    chk("irq cleared", irq, 32'h0);
    press(1);
    chk("off by remote", power_en, 32'h0);
    chk("irq off event", irq, 32'h1);
    wr(smoc_pkg::OFS_IRQ_STAT, 32'h1F);
  endtask

  task automatic t_buffer();
    always_on_bridge <= 1'b1;
    cyc(12);
    chk("on by bridge", power_en, 32'h1);
    ext_supply_ok <= 1'b0;
    cyc(300);
    chk("quiet early", buzzer, 32'h0);
    cyc(150);
    chk("final warning", buzzer, 32'h1);
    mute <= 1'b1;
    cyc(15);
    chk("muted", buzzer, 32'h0);
    cyc(175);
    chk("off on expiry", power_en, 32'h0);
    rd("events", smoc_pkg::OFS_IRQ_STAT, 32'h17);
    wr(smoc_pkg::OFS_IRQ_STAT, 32'h1F);
    {mute, always_on_bridge, ext_supply_ok} <= 3'b001;
    cyc(12);
  endtask

  task automatic t_net();
    net_above_2v <= 1'b1;
    net_above_3v <= 1'b1;
    cyc(12);
    chk("on by network", power_en, 32'h1);
    net_above_3v <= 1'b0;
    net_above_2v <= 1'b0;
    cyc(12);
    chk("off by network", power_en, 32'h0);
  endtask

  task automatic t_base();
    attach <= 1'b1;
    slow <= 1'b1;
    cyc(12);
    press(2);
    chk("on by base", power_en, 32'h1);
    press(1);
    chk("shutdown sent", shutdown_cmd, 32'h1);
    chk("kept on", power_en, 32'h1);
    cyc(60);
    chk("off after base", power_en, 32'h0);
    chk("shutdown done", shutdown_cmd, 32'h0);
    attach <= 1'b0;
    cyc(12);
  endtask

  task automatic t_reset_btn();
    press(0);
    reset_button <= 1'b1;
    cyc(12);
    chk("forced off", power_en, 32'h0);
    press(0);
    chk("on refused", power_en, 32'h0);
    reset_button <= 1'b0;
    cyc(12);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {remote_on, remote_off, always_on_bridge, mute, net_above_3v, net_above_2v} = '0;
    {base_button, reset_button, attach, slow} = '0;
    buf_sel = 4'hF;
    {checked, n_mismatch} = '0;
    ext_supply_ok = 1'b1;
    presetn = 1'b0;
    cyc(16);
    presetn <= 1'b1;
    cyc(12);
    t_regs();
    t_remote();
    t_buffer();
    t_net();
    t_base();
    t_reset_btn();
    end_of_test();
  end
endmodule // test_supply_module_on_off_control

// >>> verilog/smoc_ctrl.sv
`timescale 1ns/100ps
module smoc_ctrl #(
  parameter int unsigned DB_CYC = smoc_pkg::DEBOUNCE_CYC,
  parameter int unsigned TICK_CYC = smoc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Remote terminal contacts
  input wire logic remote_on,
  input wire logic remote_off,
  input wire logic always_on_bridge,
  input wire logic mute,
  // Supply and network thresholds
  input wire logic ext_supply_ok,
  input wire logic net_above_3v,
  input wire logic net_above_2v,
  // Base unit link
  input wire logic base_attached,
  input wire logic base_button,
  input wire logic base_active,
  // Front panel
  input wire logic reset_button,
  input wire logic [3:0] buf_sel,
  // Outputs
  output logic power_en,
  output logic shutdown_cmd,
  output logic buzzer,
  output logic irq
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
  localparam int IW = smoc_pkg::IN_W;

  typedef struct packed {
    smoc_pkg::smoc_state_t st;
    logic [IW-1:0] prev;
    logic [3:0] sel;
    logic [15:0] remain;
    logic [TW-1:0] tick;
    logic batt;
    logic expired;
    logic base_seen;
    logic [smoc_pkg::CTRL_W-1:0] ctrl;
    logic [smoc_pkg::IRQ_W-1:0] istat;
    logic [smoc_pkg::IRQ_W-1:0] imask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic power_en;
    logic shutdown_cmd;
    logic buzzer;
    logic irq;
  } smoc_regs_t;

  smoc_regs_t q, d;
  logic [IW-1:0] raw;
  logic [IW-1:0] db;
  // Filtered selector position; a turning switch passes through other codes
  logic [3:0] sel_db;

  // ==========================================================================
  // Address decode, used by the error answer; the read mux has its own case
  // Keeps the error answer in step with the read mux
  function automatic logic smoc_mapped(input logic [7:0] a);
    smoc_mapped = (a == smoc_pkg::OFS_CTRL) || (a == smoc_pkg::OFS_STATUS) ||
                  (a == smoc_pkg::OFS_IRQ_STAT) || (a == smoc_pkg::OFS_IRQ_MASK);
  endfunction

  // ==========================================================================
  // Input filtering
  // Gather every contact and threshold level except the selector into one vector
  // One filter instance keeps all contacts on the same delay
  always_comb begin
    raw = '0;
    raw[smoc_pkg::IN_ON] = remote_on;
    raw[smoc_pkg::IN_OFF] = remote_off;
    raw[smoc_pkg::IN_AON] = always_on_bridge;
    raw[smoc_pkg::IN_MUTE] = mute;
    raw[smoc_pkg::IN_EXT] = ext_supply_ok;
    raw[smoc_pkg::IN_BASE] = base_attached;
    raw[smoc_pkg::IN_BBTN] = base_button;
    raw[smoc_pkg::IN_BACT] = base_active;
    raw[smoc_pkg::IN_N3] = net_above_3v;
    raw[smoc_pkg::IN_N2] = net_above_2v;
    raw[smoc_pkg::IN_RSTB] = reset_button;
  end

  // Contact bounce must not look like a second press
  smoc_debounce #(
    .W(IW),
    .CYC(DB_CYC)
  ) u_db (
    .pclk(pclk),
    .presetn(presetn),
    .raw(raw),
    .clean(db)
  );

  // Selector contacts bounce too while the switch is turned
  smoc_debounce #(
    .W(4),
    .CYC(DB_CYC)
  ) u_sel_db (
    .pclk(pclk),
    .presetn(presetn),
    .raw(buf_sel),
    .clean(sel_db)
  );

  // ==========================================================================
  // Sequencing logic
  // All decisions use the filtered levels only
  logic [IW-1:0] rise;
  logic [IW-1:0] fall;
  logic ext;
  logic base;
  logic [3:0] sel_eff;
  logic aon_now;
  logic aon_was;
  logic net_now;
  logic net_was;
  logic on_req;
  logic off_req;
  logic start_batt;
  logic exp_evt;
  logic acc_wr;
  logic setup;
  logic [smoc_pkg::IRQ_W-1:0] ev;
  logic [31:0] status;
  logic [31:0] rmux;

  always_comb begin
    d = q;
    // Edges against last cycle's filtered levels; prev clears on reset
    rise = db & ~q.prev;
    fall = ~db & q.prev;
    ext = db[smoc_pkg::IN_EXT];
    base = db[smoc_pkg::IN_BASE];
    d.prev = db;
    d.sel = sel_db;
    sel_eff = q.ctrl[smoc_pkg::CTRL_OVR_BIT] ? q.ctrl[smoc_pkg::CTRL_SEL_LSB +: 4] : q.sel;

    // Level conditions are edge-detected so a forced off is not undone
    // Limitation: after a reset-button off, the bridge or network level must drop first
    aon_now = ext & db[smoc_pkg::IN_AON];
    aon_was = q.prev[smoc_pkg::IN_EXT] & q.prev[smoc_pkg::IN_AON];
    net_now = ext & db[smoc_pkg::IN_N3];
    net_was = q.prev[smoc_pkg::IN_EXT] & q.prev[smoc_pkg::IN_N3];

    // Turn-on causes
    on_req = rise[smoc_pkg::IN_ON] |
             rise[smoc_pkg::IN_BBTN] |
             (aon_now & ~aon_was) |
             (net_now & ~net_was);

    // ==========================================================================
    // Buffer timer: starts when running without external supply
    // The seconds count is loaded once; turning the selector later only matters at position F, which stops the count
    // One-second resolution: the warning may start up to one tick early
    start_batt = 1'b0;
    exp_evt = 1'b0;
    if (q.st == smoc_pkg::SMOC_OFF || ext) begin
      d.batt = 1'b0;
      d.expired = 1'b0;
      d.tick = '0;
    end else if (!q.batt) begin
      start_batt = 1'b1;
      d.batt = 1'b1;
      d.expired = 1'b0;
      d.remain = smoc_pkg::BUF_SEC[sel_eff];
      d.tick = '0;
    end else if (!q.expired && sel_eff != smoc_pkg::SEL_MAX) begin
      // Maximum position runs until the battery itself gives out
      // Battery exhaustion is outside this logic; power simply vanishes
      if (q.remain == 16'h0000) begin
        d.expired = 1'b1;
        exp_evt = 1'b1;
      end else if (q.tick == TICK_LAST) begin
        d.tick = '0;
        d.remain = q.remain - 16'h0001;
      end else begin
        d.tick = q.tick + TW'(1);
      end
    end

    // ==========================================================================
    // Turn-off causes
    // Network drop is ignored with a base attached; the base decides then
    off_req = rise[smoc_pkg::IN_OFF] |
              fall[smoc_pkg::IN_AON] |
              exp_evt |
              (~base & fall[smoc_pkg::IN_N2]);

    // ==========================================================================
    // Remember that an attached base unit has been running
    // Without this a base that never started would switch the module off at once
    if (q.st == smoc_pkg::SMOC_OFF) begin
      d.base_seen = 1'b0;
    end else if (db[smoc_pkg::IN_BACT]) begin
      d.base_seen = 1'b1;
    end

    // ==========================================================================
    // Power state machine
    // Off: only edges turn on, so a held contact cannot restart after a forced off
    // On: off causes either cut power or ask the base to wind down
    // Shutdown: power stays up while the base finishes saving
    case (q.st)
      smoc_pkg::SMOC_OFF: begin
        if (on_req && !db[smoc_pkg::IN_RSTB]) begin
          d.st = smoc_pkg::SMOC_ON;
        end
      end
      smoc_pkg::SMOC_ON: begin
        if (off_req) begin
          // Base present: ask it to stop cleanly rather than cut power
          d.st = base ? smoc_pkg::SMOC_SHDN : smoc_pkg::SMOC_OFF;
        end else if (base && q.base_seen && !db[smoc_pkg::IN_BACT]) begin
          d.st = smoc_pkg::SMOC_OFF;
        end
      end
      smoc_pkg::SMOC_SHDN: begin
        // Waits for the base to finish saving; reset button or detaching the base is the escape
        if (!base || (q.base_seen && !db[smoc_pkg::IN_BACT])) begin
          d.st = smoc_pkg::SMOC_OFF;
        end
      end
      default: begin
        d.st = smoc_pkg::SMOC_OFF;
      end
    endcase

    // Front-panel reset overrides everything
    // Checked last so that no other cause can keep power up while it is held
    if (db[smoc_pkg::IN_RSTB]) begin
      d.st = smoc_pkg::SMOC_OFF;
    end

    // Outputs follow the next state so they leave the flip-flops with it
    d.power_en = (d.st != smoc_pkg::SMOC_OFF);
    d.shutdown_cmd = (d.st == smoc_pkg::SMOC_SHDN);

    // ==========================================================================
    // Warning only in the last seconds before forced switch-off
    // Maximum position never expires, so it never warns either
    d.buzzer = d.batt & ~d.expired & (sel_eff != smoc_pkg::SEL_MAX) &
               (d.remain <= smoc_pkg::WARN_S) &
               ~db[smoc_pkg::IN_MUTE] & (d.st != smoc_pkg::SMOC_OFF);

    // ==========================================================================
    // Interrupt events
    // Each is a one-cycle pulse; the sticky status keeps it for software
    ev = '0;
    ev[smoc_pkg::IRQ_ON] = (q.st == smoc_pkg::SMOC_OFF) && (d.st != smoc_pkg::SMOC_OFF);
    ev[smoc_pkg::IRQ_OFF] = (q.st != smoc_pkg::SMOC_OFF) && (d.st == smoc_pkg::SMOC_OFF);
    ev[smoc_pkg::IRQ_BATT] = start_batt;
    ev[smoc_pkg::IRQ_SHDN] = (q.st != smoc_pkg::SMOC_SHDN) && (d.st == smoc_pkg::SMOC_SHDN);
    ev[smoc_pkg::IRQ_EXP] = exp_evt;

    // ==========================================================================
    // APB slave: answer prepared in setup, pready high in first access cycle
    // Zero wait states cost a registered read mux in the setup cycle
    // A master that drops psel during access leaves no write behind
    setup = psel & ~penable;
    acc_wr = psel & penable & q.pready & pwrite;

    // Built from registered state, so a read sees one snapshot
    status = '0;
    status[smoc_pkg::ST_STATE_LSB +: 2] = q.st;
    status[smoc_pkg::ST_BATT_BIT] = q.batt;
    status[smoc_pkg::ST_EXP_BIT] = q.expired;
    status[smoc_pkg::ST_BUZ_BIT] = q.buzzer;
    status[smoc_pkg::ST_SEL_LSB +: 4] = sel_eff;
    status[smoc_pkg::ST_REMAIN_LSB +: 16] = q.remain;

    // Bits above each field read as zero
    rmux = '0;
    case (paddr)
      smoc_pkg::OFS_CTRL: rmux[smoc_pkg::CTRL_W-1:0] = q.ctrl;
      smoc_pkg::OFS_STATUS: rmux = status;
      smoc_pkg::OFS_IRQ_STAT: rmux[smoc_pkg::IRQ_W-1:0] = q.istat;
      smoc_pkg::OFS_IRQ_MASK: rmux[smoc_pkg::IRQ_W-1:0] = q.imask;
      default: rmux = '0;
    endcase

    d.pready = setup;
    d.pslverr = setup & ~smoc_mapped(paddr);
    d.prdata = (setup && !pwrite) ? rmux : 32'h0000_0000;

    // Register writes
    // Unmapped or read-only addresses fall through and change nothing
    if (acc_wr && paddr == smoc_pkg::OFS_CTRL) begin
      d.ctrl = pwdata[smoc_pkg::CTRL_W-1:0];
    end
    if (acc_wr && paddr == smoc_pkg::OFS_IRQ_MASK) begin
      d.imask = pwdata[smoc_pkg::IRQ_W-1:0];
    end

    // Write one to clear; a new event in the same cycle wins
    // Losing an event to a clear would hide an off from software
    d.istat = q.istat;
    if (acc_wr && paddr == smoc_pkg::OFS_IRQ_STAT) begin
      d.istat = q.istat & ~pwdata[smoc_pkg::IRQ_W-1:0];
    end
    d.istat = d.istat | ev;
    d.irq = |(d.istat & d.imask);
  end

  // ==========================================================================
  // State register
  // Named fields are set after the clear so their reset values stay explicit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= smoc_pkg::SMOC_OFF;
      q.ctrl <= smoc_pkg::CTRL_RST;
      q.istat <= smoc_pkg::IRQ_RST;
      q.imask <= smoc_pkg::IRQ_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  // No logic after the flip-flops, so pins cannot glitch
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign power_en = q.power_en;
  assign shutdown_cmd = q.shutdown_cmd;
  assign buzzer = q.buzzer;
  assign irq = q.irq;

endmodule // smoc_ctrl

// >>> verilog/smoc_debounce.sv
`timescale 1ns/100ps
module smoc_debounce #(
  parameter int W = 11,
  parameter int unsigned CYC = smoc_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] clean;
    logic [W-1:0][CW-1:0] cnt;
  } smoc_db_t;

  smoc_db_t q, d;

  // ==========================================================================
  // Two-stage sync, then a level must hold CYC cycles to be accepted
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.clean[i]) begin
        d.cnt[i] = '0;
      end else if (q.cnt[i] == LAST) begin
        d.cnt[i] = '0;
        d.clean[i] = q.s2[i];
      end else begin
        d.cnt[i] = q.cnt[i] + CW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign clean = q.clean;

endmodule // smoc_debounce

// >>> verilog/smoc_pkg.sv
package smoc_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
  localparam logic [15:0] WARN_S = 16'h000A;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

  // Control: selector override
  localparam int CTRL_W = 5;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_OVR_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Status fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_BATT_BIT = 2;
  localparam int ST_EXP_BIT = 3;
  localparam int ST_BUZ_BIT = 4;
  localparam int ST_SEL_LSB = 8;
  localparam int ST_REMAIN_LSB = 16;

  // Interrupt bits
  localparam int IRQ_ON = 0;
  localparam int IRQ_OFF = 1;
  localparam int IRQ_BATT = 2;
  localparam int IRQ_SHDN = 3;
  localparam int IRQ_EXP = 4;
  localparam int IRQ_W = 5;
  localparam logic [4:0] IRQ_RST = 5'h00;

  // Debounced input vector positions
  localparam int IN_ON = 0;
  localparam int IN_OFF = 1;
  localparam int IN_AON = 2;
  localparam int IN_MUTE = 3;
  localparam int IN_EXT = 4;
  localparam int IN_BASE = 5;
  localparam int IN_BBTN = 6;
  localparam int IN_BACT = 7;
  localparam int IN_N3 = 8;
  localparam int IN_N2 = 9;
  localparam int IN_RSTB = 10;
  localparam int IN_W = 11;

  // Selector: position F never expires by timer
  localparam logic [3:0] SEL_MAX = 4'hF;
  localparam logic [15:0] BUF_SEC [16] = '{
    16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h000A, 16'h001E, 16'h003C, 16'h0078,
    16'h012C, 16'h0258, 16'h0708, 16'h0E10, 16'h1C20, 16'h4650, 16'h8CA0, 16'hFFFF};

  typedef enum logic [1:0] {
    SMOC_OFF = 2'b00,
    SMOC_ON = 2'b01,
    SMOC_SHDN = 2'b10
  } smoc_state_t;

endpackage
